/* rtl/easpr_defs.svh */
// Purpose: Offsets, reset values and field positions of the speed and peak registers
// Assumes: Byte-wide register port, 8-bit addresses
// Notes:   Control register offset is a local choice
`ifndef EASPR_DEFS_SVH
`define EASPR_DEFS_SVH

`define EASPR_ADDR_PEAK_LOW     8'h1A
`define EASPR_ADDR_PEAK_HIGH    8'h1B
`define EASPR_ADDR_LINE_LOW     8'h1C
`define EASPR_ADDR_LINE_HIGH    8'h1D
`define EASPR_ADDR_ACOU_LOW     8'h3C
`define EASPR_ADDR_ACOU_HIGH    8'h3D
`define EASPR_ADDR_CTRL         8'h3E

`define EASPR_RST_ACOU_LOW      8'h00
`define EASPR_RST_ACOU_HIGH     8'h10
`define EASPR_RST_LINE_LOW      8'h00
`define EASPR_RST_LINE_HIGH     8'h08
`define EASPR_RST_PEAK          16'h0000
`define EASPR_RST_CTRL          8'h00

`define EASPR_CTRL_USER_BIT     0
`define EASPR_SPEED_MAX         16'h7FFF

`endif

/* rtl/easpr_pkg.sv */
// Purpose: Types shared by the speed and peak register bank
// Assumes: Defs header holds addresses and reset values; select codes are set here
// Notes:   None
package easpr_pkg;
    typedef logic [7:0]  easpr_byte_t;
    typedef logic [15:0] easpr_word_t;
    typedef enum logic [2:0] {
        EASPR_SEL_NONE      = 3'b000,
        EASPR_SEL_PEAK_LOW  = 3'b001,
        EASPR_SEL_PEAK_HIGH = 3'b010,
        EASPR_SEL_LINE_LOW  = 3'b011,
        EASPR_SEL_ACOU_LOW  = 3'b100,
        EASPR_SEL_ACOU_HIGH = 3'b101,
        EASPR_SEL_CTRL      = 3'b110,
        EASPR_SEL_LINE_HIGH = 3'b111
    } easpr_sel_t;
endpackage : easpr_pkg

/* rtl/easpr_speed_if.sv */
// Purpose: Carries one speed pair between the bank and its speed holder
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/100ps
interface easpr_speed_if;
    import easpr_pkg::*;
    logic        wr_low;
    logic        wr_high;
    easpr_byte_t wdata;
    easpr_word_t auto_value;
    logic        auto_load;
    easpr_word_t value;
    modport bank   (output wr_low, output wr_high, output wdata, output auto_value,
                    output auto_load, input value);
    modport holder (input wr_low, input wr_high, input wdata, input auto_value,
                    input auto_load, output value);
endinterface : easpr_speed_if

/* rtl/easpr_speed_reg.sv */
// Purpose: Holds one 16-bit adaptation speed pair
// Assumes: Writes and automatic loads come from the same clock
// Notes:   Automatic load wins while user control is off
`timescale 1ns/100ps
module easpr_speed_reg #(
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clk_en_i,
    easpr_speed_if.holder         spd
);
    import easpr_pkg::*;

    easpr_word_t next_value;
    easpr_word_t value_q;

    // Select among automatic load, byte writes and hold
    always_comb
    begin
        next_value = value_q;
        if (spd.auto_load)
        begin
            next_value = spd.auto_value;
        end
        else
        begin
            if (spd.wr_low)
            begin
                next_value[7:0] = spd.wdata;
            end
            if (spd.wr_high)
            begin
                next_value[15:8] = spd.wdata;
            end
        end
    end

    // Storage
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            value_q <= RESET_VALUE;
        end
        else if (clk_en_i)
        begin
            value_q <= next_value;
        end
    end

    assign spd.value = value_q;
endmodule : easpr_speed_reg

/* rtl/easpr_bank.sv */
// Purpose: Send-out peak monitor and canceller adaptation speed registers
// Assumes: Peak and automatic speed values come from core logic on core_clk_i
// Notes:   Read data stand only in the cycle after the read strobe
`timescale 1ns/100ps
`include "easpr_defs.svh"

module easpr_bank (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   clk_en_i,
    input  wire logic [7:0]             addr_i,
    input  wire easpr_pkg::easpr_byte_t wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output easpr_pkg::easpr_byte_t      rdata_o,
    input  wire easpr_pkg::easpr_word_t peak_i,
    input  wire logic                   peak_valid_i,
    input  wire easpr_pkg::easpr_word_t acou_auto_i,
    input  wire easpr_pkg::easpr_word_t line_auto_i,
    input  wire logic                   auto_valid_i,
    output easpr_pkg::easpr_word_t      acou_speed_o,
    output easpr_pkg::easpr_word_t      line_speed_o,
    output logic                        speed_user_control_bit_o
);
    import easpr_pkg::*;

    // Speed pairs held here: acoustic first, line second
    localparam int N_PAIRS   = 2;
    localparam int PAIR_ACOU = 0;
    localparam int PAIR_LINE = 1;

    easpr_speed_if spd_if [N_PAIRS] ();

    easpr_word_t        send_out_peak_value;
    easpr_byte_t        ctrl;
    easpr_byte_t        rdata_q;
    easpr_byte_t        next_rdata;
    easpr_byte_t        peak_rbyte;
    easpr_byte_t        pair_rbyte [N_PAIRS];
    easpr_word_t        pair_auto  [N_PAIRS];
    easpr_sel_t         sel;
    logic               user_ctl;
    logic               auto_load;
    logic               ctrl_wr;
    logic               hit_peak_low;
    logic               hit_peak_high;
    logic               hit_peak;
    logic               hit_ctrl;
    logic [N_PAIRS-1:0] pair_hit_low;
    logic [N_PAIRS-1:0] pair_hit_high;
    logic [N_PAIRS-1:0] pair_hit;

    // Power-up value of one speed pair, by pair index
    function automatic easpr_word_t pair_reset(input int idx);
        if (idx == PAIR_ACOU)
        begin
            pair_reset = {`EASPR_RST_ACOU_HIGH, `EASPR_RST_ACOU_LOW};
        end
        else
        begin
            pair_reset = {`EASPR_RST_LINE_HIGH, `EASPR_RST_LINE_LOW};
        end
    endfunction : pair_reset

    // One byte of a 16-bit value: high byte when hi is set
    function automatic easpr_byte_t pick_byte(input easpr_word_t w, input logic hi);
        pick_byte = hi ? w[15:8] : w[7:0];
    endfunction : pick_byte

    // Address decoder, shared by read and write paths
    function automatic easpr_sel_t decode(input logic [7:0] a);
        unique case (a)
            `EASPR_ADDR_PEAK_LOW:  decode = EASPR_SEL_PEAK_LOW;
            `EASPR_ADDR_PEAK_HIGH: decode = EASPR_SEL_PEAK_HIGH;
            `EASPR_ADDR_LINE_LOW:  decode = EASPR_SEL_LINE_LOW;
            `EASPR_ADDR_LINE_HIGH: decode = EASPR_SEL_LINE_HIGH;
            `EASPR_ADDR_ACOU_LOW:  decode = EASPR_SEL_ACOU_LOW;
            `EASPR_ADDR_ACOU_HIGH: decode = EASPR_SEL_ACOU_HIGH;
            `EASPR_ADDR_CTRL:      decode = EASPR_SEL_CTRL;
            default:               decode = EASPR_SEL_NONE;
        endcase
    endfunction : decode

    // Register hits from the shared decoder; peak addresses take no write
    assign sel                      = decode(addr_i);
    assign hit_peak_low             = (sel == EASPR_SEL_PEAK_LOW);
    assign hit_peak_high            = (sel == EASPR_SEL_PEAK_HIGH);
    assign hit_ctrl                 = (sel == EASPR_SEL_CTRL);
    assign pair_hit_low[PAIR_ACOU]  = (sel == EASPR_SEL_ACOU_LOW);
    assign pair_hit_high[PAIR_ACOU] = (sel == EASPR_SEL_ACOU_HIGH);
    assign pair_hit_low[PAIR_LINE]  = (sel == EASPR_SEL_LINE_LOW);
    assign pair_hit_high[PAIR_LINE] = (sel == EASPR_SEL_LINE_HIGH);

    // User control bit; while it is low the hardware speeds win
    assign user_ctl  = ctrl[`EASPR_CTRL_USER_BIT];
    assign ctrl_wr   = wr_i && hit_ctrl;
    assign auto_load = !user_ctl && auto_valid_i;

    // Hardware-computed speeds, by pair index
    assign pair_auto[PAIR_ACOU] = acou_auto_i;
    assign pair_auto[PAIR_LINE] = line_auto_i;

    // One holder per speed pair; both follow the same user control bit
    for (genvar g = 0; g < N_PAIRS; g++)
    begin : g_pair
        assign spd_if[g].wr_low     = wr_i && pair_hit_low[g];
        assign spd_if[g].wr_high    = wr_i && pair_hit_high[g];
        assign spd_if[g].wdata      = wdata_i;
        assign spd_if[g].auto_value = pair_auto[g];
        assign spd_if[g].auto_load  = auto_load;
        assign pair_hit[g]          = pair_hit_low[g] || pair_hit_high[g];
        assign pair_rbyte[g]        = pick_byte(spd_if[g].value, pair_hit_high[g]);

        easpr_speed_reg #(
            .RESET_VALUE (pair_reset(g))
        ) u_speed (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .clk_en_i   (clk_en_i),
            .spd        (spd_if[g].holder)
        );
    end

    // Control register; only the user control bit has a meaning
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl <= `EASPR_RST_CTRL;
        end
        else if (clk_en_i && ctrl_wr)
        begin
            ctrl <= wdata_i;
        end
    end

    // Peak capture from the send-out detector; no bus write reaches it
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            send_out_peak_value <= `EASPR_RST_PEAK;
        end
        else if (clk_en_i && peak_valid_i)
        begin
            send_out_peak_value <= peak_i;
        end
    end

    // Peak bytes are read live, no latching between the two halves
    assign hit_peak   = hit_peak_low || hit_peak_high;
    assign peak_rbyte = pick_byte(send_out_peak_value, hit_peak_high);

    // Read multiplexer as an AND-OR of the hits; unmapped addresses read zero
    assign next_rdata = ({8{hit_peak}} & peak_rbyte)
                      | ({8{pair_hit[PAIR_ACOU]}} & pair_rbyte[PAIR_ACOU])
                      | ({8{pair_hit[PAIR_LINE]}} & pair_rbyte[PAIR_LINE])
                      | ({8{hit_ctrl}} & ctrl);

    // Read data stand one cycle, zero otherwise
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_q <= 8'h00;
        end
        else if (clk_en_i)
        begin
            rdata_q <= rd_i ? next_rdata : 8'h00;
        end
    end

    // Outputs straight from the registers
    assign rdata_o                  = rdata_q;
    assign acou_speed_o             = spd_if[PAIR_ACOU].value;
    assign line_speed_o             = spd_if[PAIR_LINE].value;
    assign speed_user_control_bit_o = user_ctl;
endmodule : easpr_bank

/* test/easpr_bank_assertions.sv */
// Purpose: Port checks for the speed and peak register bank
// Assumes: One clock, reset active high
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
module easpr_bank_chk (
    input wire logic                   core_clk_i,
    input wire logic                   rst_i,
    input wire logic                   clk_en_i,
    input wire logic [7:0]             addr_i,
    input wire easpr_pkg::easpr_byte_t wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire easpr_pkg::easpr_byte_t rdata_o,
    input wire easpr_pkg::easpr_word_t peak_i,
    input wire logic                   peak_valid_i,
    input wire easpr_pkg::easpr_word_t acou_auto_i,
    input wire easpr_pkg::easpr_word_t line_auto_i,
    input wire logic                   auto_valid_i,
    input wire easpr_pkg::easpr_word_t acou_speed_o,
    input wire easpr_pkg::easpr_word_t line_speed_o,
    input wire logic                   speed_user_control_bit_o
);
    import easpr_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Captured peak bytes reach the read port
    a_peak_low_read: assert property ((peak_valid_i && clk_en_i) ##1 (rd_i && clk_en_i
        && addr_i == 8'h1A && !peak_valid_i) |=> rdata_o == $past(peak_i[7:0], 2))
        else $error("peak low byte read wrong");
    a_peak_high_read: assert property ((peak_valid_i && clk_en_i) ##1 (rd_i && clk_en_i
        && addr_i == 8'h1B && !peak_valid_i) |=> rdata_o == $past(peak_i[15:8], 2))
        else $error("peak high byte read wrong");
    // User writes land while user control is on
    a_acou_write: assert property (wr_i && clk_en_i && speed_user_control_bit_o
        && addr_i == 8'h3C |=> acou_speed_o[7:0] == $past(wdata_i))
        else $error("acoustic low byte not written");
    a_line_write: assert property (wr_i && clk_en_i && speed_user_control_bit_o
        && addr_i == 8'h1C |=> line_speed_o[7:0] == $past(wdata_i))
        else $error("line low byte not written");
    // Hardware speeds override while user control is off
    a_auto_load: assert property (auto_valid_i && clk_en_i && !speed_user_control_bit_o
        |=> acou_speed_o == $past(acou_auto_i) && line_speed_o == $past(line_auto_i))
        else $error("automatic speed not loaded");
    // Exported speed matches what software reads
    a_speed_read: assert property (rd_i && clk_en_i && speed_user_control_bit_o
        && addr_i == 8'h3D |=> rdata_o == $past(acou_speed_o[15:8]))
        else $error("speed readback differs from output");
endmodule : easpr_bank_chk

/* test/easpr_bank_tb_top.sv */
// Purpose: Self-checking bench for the speed and peak register bank
// Assumes: Clock enable high except in one freeze test
// Notes:   Register port driven by tasks
`timescale 1ns/100ps
module easpr_bank_tb_top;
    import easpr_pkg::*;
    logic        core_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, ctl;
    logic        peak_valid_i = 0, auto_valid_i = 0;
    logic        clk_en_i = 1'b1;
    logic [7:0]  addr_i = 8'h00, ra[8], re[8];
    easpr_byte_t wdata_i = 8'h00, rdata_o;
    easpr_word_t peak_i = 16'h0000, acou_auto_i = 16'h0000, line_auto_i = 16'h0000;
    easpr_word_t acou_speed_o, line_speed_o;
    int          n_errors = 0, compares = 0;
    // Free-running clock
    always #5 core_clk_i = ~core_clk_i;
    easpr_bank u_dut (.core_clk_i, .rst_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .peak_i, .peak_valid_i, .acou_auto_i, .line_auto_i, .auto_valid_i,
        .acou_speed_o, .line_speed_o, .speed_user_control_bit_o(ctl));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, zero after that
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        rd_i         <= 1'b1;
        addr_i       <= a;
        peak_valid_i <= 1'b0;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 chk({8'h00, rdata_o}, {8'h00, e});
        @(posedge core_clk_i);
        #1 chk({8'h00, rdata_o}, 16'h0000);
    endtask : rd
    task results;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    // Watchdog
    initial
    begin
        #20000;
        n_errors++;
        results();
    end
    initial
    begin
        ra = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h3C, 8'h3D, 8'h3E, 8'h50};
        re = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h10, 8'h00, 8'h00};
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        foreach (ra[i]) rd(ra[i], re[i]);
        @(posedge core_clk_i);
        peak_valid_i <= 1'b1;
        peak_i       <= 16'h8A5C;
        rd(8'h1A, 8'h5C);
        @(posedge core_clk_i);
        peak_valid_i <= 1'b1;
        rd(8'h1B, 8'h8A);
        wr(8'h1A, 8'hFF);
        rd(8'h1A, 8'h5C);
        // Hardware speeds win over a software write
        @(posedge core_clk_i);
        auto_valid_i <= 1'b1;
        acou_auto_i  <= 16'h1234;
        line_auto_i  <= 16'h0567;
        wr(8'h3C, 8'hAA);
        rd(8'h3C, 8'h34);
        rd(8'h3D, 8'h12);
        rd(8'h1C, 8'h67);
        // User control, top of the valid range; outputs settle before the compare
        wr(8'h3E, 8'h01);
        wr(8'h3C, 8'hFF);
        wr(8'h3D, 8'h7F);
        wr(8'h1D, 8'h02);
        wr(8'h1C, 8'h00);
        #1 chk(acou_speed_o, 16'h7FFF);
        chk(line_speed_o, 16'h0200);
        chk({15'h0000, ctl}, 16'h0001);
        // Clock enable low freezes a write
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        wr(8'h3C, 8'h55);
        #1 chk(acou_speed_o, 16'h7FFF);
        @(posedge core_clk_i);
        clk_en_i <= 1'b1;
        rd(8'h3D, 8'h7F);
        wr(8'h3E, 8'h00);
        rd(8'h3C, 8'h34);
        rd(8'h1C, 8'h67);
        results();
    end
endmodule : easpr_bank_tb_top
bind easpr_bank easpr_bank_chk u_chk (.core_clk_i, .rst_i, .clk_en_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .peak_i, .peak_valid_i, .acou_auto_i, .line_auto_i,
    .auto_valid_i, .acou_speed_o, .line_speed_o, .speed_user_control_bit_o);
